/* File: core/tws_regs.svh */
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH
`define TWS_OFS_CTRL 8'h00
`define TWS_OFS_DATA 8'h04
`define TWS_OFS_STATUS 8'h08
`define TWS_OFS_BITRATE 8'h0c
`define TWS_CTRL_FLAG 7
`define TWS_CTRL_START 5
`define TWS_CTRL_STOP 4
`define TWS_CTRL_EN 2
`define TWS_CTRL_IE 0
`define TWS_BITRATE_RST 8'h3e
`define TWS_DATA_RST 8'hff
`define TWS_ST_START 8'h08
`define TWS_ST_RSTART 8'h10
`define TWS_ST_ADDR_ACK 8'h18
`define TWS_ST_ADDR_NACK 8'h20
`define TWS_ST_DATA_ACK 8'h28
`define TWS_ST_DATA_NACK 8'h30
`define TWS_ST_NONE 8'hf8
`define TWS_LAST_BIT 4'h8
`endif

/* File: core/tws_pkg.sv */
`default_nettype none
package tws_pkg;
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_START = 3'b001,
		ST_WAIT = 3'b011,
		ST_BIT = 3'b010,
		ST_STOP = 3'b110
	} tws_state_type;

	typedef struct packed
	{
		tws_state_type state;
		logic [1:0] phase;
		logic [7:0] cnt;
		logic [3:0] bitIdx;
		logic inFrame;
		logic addrPhase;
		logic ackBit;
		logic flag;
		logic pend;
		logic [7:0] evtCode;
		logic [7:0] status;
		logic [7:0] data;
		logic [7:0] bitrate;
		logic ctrlIe;
		logic ctrlEn;
		logic ctrlStart;
		logic ctrlStop;
		logic busSel;
		logic busWr;
		logic [7:0] busAddr;
		logic sclMeta;
		logic sclSync;
		logic sdaMeta;
		logic sdaSync;
		logic sclOe;
		logic sdaOe;
		logic irq;
		logic [31:0] hrdata;
	} tws_reg_type;
endpackage
`default_nettype wire

/* File: core/tws_ctrl.sv */
`include "tws_regs.svh"
`default_nettype none
module tws_ctrl
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic gieIn,
	output logic irqReq,
	input wire logic sclIn,
	output logic sclOut,
	output logic sclOe,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe
);
	tws_pkg::tws_reg_type r;
	tws_pkg::tws_reg_type nxt;
	logic addrPhaseOk;
	logic wrCtrl;
	logic wrData;
	logic wrRate;
	logic tick;
	logic [7:0] rdSel;

	// data-phase write strobes
	always_comb
	begin
		wrCtrl = r.busSel && r.busWr && (r.busAddr == `TWS_OFS_CTRL);
		wrData = r.busSel && r.busWr && (r.busAddr == `TWS_OFS_DATA);
		wrRate = r.busSel && r.busWr && (r.busAddr == `TWS_OFS_BITRATE);
		addrPhaseOk = hsel && htrans[1] && hready;
		tick = (r.cnt == 8'h00);
	end

	always_comb
	begin
		nxt = r;
		rdSel = 8'h00;
		nxt.sclMeta = sclIn;
		nxt.sclSync = r.sclMeta;
		nxt.sdaMeta = sdaIn;
		nxt.sdaSync = r.sdaMeta;
		nxt.cnt = tick ? 8'h00 : r.cnt - 8'h01;

		// control write; reads have no side effect
		if (wrCtrl)
		begin
			nxt.ctrlIe = hwdata[`TWS_CTRL_IE];
			nxt.ctrlEn = hwdata[`TWS_CTRL_EN];
			nxt.ctrlStart = hwdata[`TWS_CTRL_START];
			nxt.ctrlStop = hwdata[`TWS_CTRL_STOP];
			if (hwdata[`TWS_CTRL_FLAG])
			begin
				nxt.flag = 1'b0;
				nxt.pend = 1'b1;
			end
		end
		// data only written while flag set
		if (wrData && r.flag)
		begin
			nxt.data = hwdata[7:0];
		end
		if (wrRate)
		begin
			nxt.bitrate = hwdata[7:0];
		end

		case (r.state)
			tws_pkg::ST_IDLE:
			begin
				nxt.sclOe = 1'b0;
				nxt.sdaOe = 1'b0;
				if (nxt.pend && !nxt.flag && nxt.ctrlEn && nxt.ctrlStart)
				begin
					nxt.pend = 1'b0;
					nxt.state = tws_pkg::ST_START;
					nxt.phase = 2'd0;
					nxt.cnt = r.bitrate;
				end
				else
				begin
					nxt.pend = 1'b0;
				end
			end
			tws_pkg::ST_START:
			begin
				case (r.phase)
					2'd0:
					begin
						nxt.sdaOe = 1'b0;
						if (tick)
						begin
							nxt.phase = 2'd1;
							nxt.sclOe = 1'b0;
						end
					end
					2'd1:
					begin
						if (r.sclSync)
						begin
							nxt.phase = 2'd2;
							nxt.cnt = r.bitrate;
						end
					end
					2'd2:
					begin
						if (tick)
						begin
							nxt.sdaOe = 1'b1;
							nxt.phase = 2'd3;
							nxt.cnt = r.bitrate;
						end
					end
					default:
					begin
						if (tick)
						begin
							nxt.sclOe = 1'b1;
							nxt.flag = 1'b1;
							nxt.evtCode = r.inFrame ? `TWS_ST_RSTART : `TWS_ST_START;
							nxt.inFrame = 1'b1;
							nxt.addrPhase = 1'b1;
							nxt.state = tws_pkg::ST_WAIT;
						end
					end
				endcase
			end
			tws_pkg::ST_WAIT:
			begin
				nxt.sclOe = 1'b1;
				if (!nxt.flag && nxt.pend)
				begin
					nxt.pend = 1'b0;
					nxt.phase = 2'd0;
					nxt.cnt = r.bitrate;
					if (!nxt.ctrlEn)
					begin
						nxt.state = tws_pkg::ST_IDLE;
						nxt.inFrame = 1'b0;
					end
					else if (nxt.ctrlStop)
					begin
						nxt.state = tws_pkg::ST_STOP;
					end
					else if (nxt.ctrlStart)
					begin
						nxt.state = tws_pkg::ST_START;
					end
					else
					begin
						nxt.state = tws_pkg::ST_BIT;
						nxt.bitIdx = 4'h0;
					end
				end
			end
			tws_pkg::ST_BIT:
			begin
				case (r.phase)
					2'd0:
					begin
						if (r.bitIdx == `TWS_LAST_BIT)
						begin
							nxt.sdaOe = 1'b0;
						end
						else
						begin
							nxt.sdaOe = ~r.data[3'd7 - r.bitIdx[2:0]];
						end
						if (tick)
						begin
							nxt.sclOe = 1'b0;
							nxt.phase = 2'd1;
						end
					end
					2'd1:
					begin
						if (r.sclSync)
						begin
							nxt.phase = 2'd2;
							nxt.cnt = r.bitrate;
						end
					end
					default:
					begin
						if (tick)
						begin
							nxt.sclOe = 1'b1;
							nxt.cnt = r.bitrate;
							nxt.phase = 2'd0;
							nxt.bitIdx = r.bitIdx + 4'h1;
							if (r.bitIdx == `TWS_LAST_BIT)
							begin
								nxt.ackBit = ~r.sdaSync;
								nxt.flag = 1'b1;
								nxt.state = tws_pkg::ST_WAIT;
								nxt.addrPhase = 1'b0;
								if (r.addrPhase)
								begin
									nxt.evtCode = r.sdaSync ? `TWS_ST_ADDR_NACK
										: `TWS_ST_ADDR_ACK;
								end
								else
								begin
									nxt.evtCode = r.sdaSync ? `TWS_ST_DATA_NACK
										: `TWS_ST_DATA_ACK;
								end
							end
						end
					end
				endcase
			end
			tws_pkg::ST_STOP:
			begin
				case (r.phase)
					2'd0:
					begin
						nxt.sclOe = 1'b1;
						nxt.sdaOe = 1'b1;
						if (tick)
						begin
							nxt.sclOe = 1'b0;
							nxt.phase = 2'd1;
						end
					end
					2'd1:
					begin
						if (r.sclSync)
						begin
							nxt.phase = 2'd2;
							nxt.cnt = r.bitrate;
						end
					end
					default:
					begin
						if (tick)
						begin
							nxt.sdaOe = 1'b0;
							nxt.ctrlStop = 1'b0;
							nxt.inFrame = 1'b0;
							nxt.state = tws_pkg::ST_IDLE;
						end
					end
				endcase
			end
			default:
			begin
				nxt.state = tws_pkg::ST_IDLE;
			end
		endcase

		// status lags flag by one cycle
		nxt.status = r.flag ? r.evtCode : `TWS_ST_NONE;
		nxt.irq = r.flag && r.ctrlIe && gieIn;

		// address phase; read data from next-state values
		nxt.busSel = addrPhaseOk;
		nxt.busWr = hwrite;
		nxt.busAddr = haddr[7:0];
		if (addrPhaseOk && !hwrite && (haddr[31:8] == 24'h000000))
		begin
			case (haddr[7:0])
				`TWS_OFS_CTRL:
				begin
					rdSel = 8'h00;
					rdSel[`TWS_CTRL_FLAG] = nxt.flag;
					rdSel[`TWS_CTRL_START] = nxt.ctrlStart;
					rdSel[`TWS_CTRL_STOP] = nxt.ctrlStop;
					rdSel[`TWS_CTRL_EN] = nxt.ctrlEn;
					rdSel[`TWS_CTRL_IE] = nxt.ctrlIe;
				end
				`TWS_OFS_DATA:
				begin
					rdSel = nxt.data;
				end
				`TWS_OFS_STATUS:
				begin
					rdSel = nxt.status;
				end
				`TWS_OFS_BITRATE:
				begin
					rdSel = nxt.bitrate;
				end
				default:
				begin
					rdSel = 8'h00;
				end
			endcase
		end
		if (haddr[31:8] != 24'h000000)
		begin
			nxt.busSel = 1'b0;
		end
		nxt.hrdata = {24'h000000, rdSel};
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			r <= '0;
			r.state <= tws_pkg::ST_IDLE;
			r.status <= `TWS_ST_NONE;
			r.evtCode <= `TWS_ST_NONE;
			r.data <= `TWS_DATA_RST;
			r.bitrate <= `TWS_BITRATE_RST;
			r.sclMeta <= 1'b1;
			r.sclSync <= 1'b1;
			r.sdaMeta <= 1'b1;
			r.sdaSync <= 1'b1;
		end
		else
		begin
			r <= nxt;
		end
	end

	// read data, irq and line enables straight from the state register; ready, resp and pin values constant
	assign hrdata = r.hrdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign irqReq = r.irq;
	assign sclOut = 1'b0;
	assign sdaOut = 1'b0;
	assign sclOe = r.sclOe;
	assign sdaOe = r.sdaOe;
endmodule
`default_nettype wire

/* File: verification/tws_ctrl_asserts.sv */
`default_nettype none
module tws_ctrl_asserts
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic gieIn,
	input wire logic irqReq,
	input wire logic sclOut,
	input wire logic sclOe,
	input wire logic sdaOut,
	input wire logic sdaOe
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_irq_gie: assert property (irqReq |-> $past(gieIn))
		else $error("irq raised without global enable");
	a_irq_masked: assert property (!gieIn |=> !irqReq)
		else $error("irq stays up after global enable drop");
	a_scl_stall: assert property (irqReq |-> sclOe)
		else $error("clock line released while flag set");
	a_lines_hold: assert property (irqReq && $past(irqReq)
		|-> $stable(sdaOe) && $stable(sclOe))
		else $error("bus lines moved while flag set");
	a_start_flag: assert property ($rose(sdaOe) && !sclOe |-> ##[1:1000] irqReq)
		else $error("no flag after start condition");
	a_stop_quiet: assert property ($fell(sdaOe) && !sclOe |-> !irqReq [*8])
		else $error("flag raised after stop condition");
	a_drain_low: assert property (sclOut == 1'b0 && sdaOut == 1'b0)
		else $error("open drain value not low");
	a_bus_okay: assert property (hreadyout && !hresp && hrdata[31:8] == 24'h0)
		else $error("bus answer not ready, okay and byte wide");
endmodule
bind tws_ctrl tws_ctrl_asserts chk (.mclk(mclk), .rst(rst), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .gieIn(gieIn), .irqReq(irqReq),
	.sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe));
`default_nettype wire

/* File: verification/tws_slave.sv */
`default_nettype none
module tws_slave
#(
	parameter logic [6:0] SLV_ADDR = 7'h2a
)
(
	input wire logic scl,
	input wire logic sda,
	output logic ackOe = 1'b0,
	output logic [7:0] lastByte = 8'h00
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] shiftIn = 8'h00;
	int bitCnt = 0;
	logic firstByte = 1'b0;
	logic addressed = 1'b0;
	// start or repeated start restarts the byte
	always @(negedge sda)
	begin
		if (scl)
		begin
			bitCnt = 0;
			firstByte = 1'b1;
		end
	end
	always @(posedge scl)
	begin
		if (bitCnt < 8)
		begin
			shiftIn = {shiftIn[6:0], sda};
			bitCnt++;
		end
	end
	// acknowledge only when addressed, released after the ninth clock
	always @(negedge scl)
	begin
		if (bitCnt == 8)
		begin
			if (firstByte)
				addressed = (shiftIn == {SLV_ADDR, 1'b0});
			ackOe <= addressed;
			lastByte <= shiftIn;
			bitCnt = 9;
		end
		else if (bitCnt == 9)
		begin
			ackOe <= 1'b0;
			bitCnt = 0;
			firstByte = 1'b0;
		end
	end
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
`include "tws_regs.svh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic gieIn = 1'b1;
	wire logic [31:0] hrdata;
	wire logic hreadyout, hresp, irqReq, sclOut, sclOe, sdaOut, sdaOe, ackOe;
	wire logic [7:0] slvByte;
	wire logic sclLine = !sclOe;
	wire logic sdaLine = !(sdaOe || ackOe);
	int errCount = 0;
	int checksDone = 0;
	tws_ctrl uut (.mclk(mclk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .gieIn(gieIn),
		.irqReq(irqReq), .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe),
		.sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe));
	tws_slave slv (.scl(sclLine), .sda(sdaLine), .ackOe(ackOe), .lastByte(slvByte));
	initial forever #4 mclk = ~mclk;
	task automatic test_done();
		$display("checks %0d mismatches %0d", checksDone, errCount);
		if (errCount == 0 && checksDone > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		checksDone++;
		if (got !== exp)
		begin
			errCount++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic busOp(input logic [7:0] a, input logic w, input logic [7:0] d,
		output logic [7:0] q);
		int n = 0;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		@(posedge mclk);
		while (hreadyout !== 1'b1 && n++ < 100) @(posedge mclk);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		@(posedge mclk);
		while (hreadyout !== 1'b1 && n++ < 100) @(posedge mclk);
		q = hrdata[7:0];
		if (n >= 100)
		begin
			errCount++;
			test_done();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		busOp(a, 1'b1, d, q);
	endtask
	task automatic rdc(input string w, input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] q;
		busOp(a, 1'b0, 8'h00, q);
		check(w, exp, q);
	endtask
	// software waits by reading control until the bit settles
	task automatic poll(input int b, input logic v);
		logic [7:0] q;
		for (int i = 0; i < 400; i++)
		begin
			busOp(8'h00, 1'b0, 8'h00, q);
			if (q[b] === v)
				return;
		end
		errCount++;
		test_done();
	endtask
	task automatic t_reset();
		rdc("status", 8'h08, 8'hf8);
		rdc("shift data", 8'h04, 8'hff);
		rdc("bit rate", 8'h0c, 8'h3e);
		rdc("unmapped", 8'h10, 8'h00);
		$display("reset test done");
	endtask
	task automatic t_xfer(input logic [7:0] sla, input logic [7:0] dat, input logic ok);
		logic [7:0] q;
		wr(8'h00, 8'ha5);
		poll(7, 1'b1);
		rdc("start code", 8'h08, `TWS_ST_START);
		busOp(8'h08, 1'b0, 8'h00, q);
		check("masked start", `TWS_ST_START, q & 8'hf8);
		check("irq", 8'h01, {7'h0, irqReq});
		check("scl line", 8'h00, {7'h0, sclLine});
		gieIn <= 1'b0;
		repeat (3) @(posedge mclk);
		check("irq masked", 8'h00, {7'h0, irqReq});
		gieIn <= 1'b1;
		wr(8'h04, sla);
		rdc("shift data", 8'h04, sla);
		wr(8'h00, 8'h25);
		rdc("flag kept", 8'h00, 8'ha5);
		wr(8'h00, 8'h85);
		poll(7, 1'b1);
		rdc("addr code", 8'h08, ok ? `TWS_ST_ADDR_ACK : `TWS_ST_ADDR_NACK);
		check("addr byte", sla, slvByte);
		wr(8'h04, dat);
		wr(8'h00, 8'h85);
		poll(7, 1'b1);
		rdc("data code", 8'h08, ok ? `TWS_ST_DATA_ACK : `TWS_ST_DATA_NACK);
		check("data byte", dat, slvByte);
		if (!ok)
		begin
			wr(8'h00, 8'ha5);
			poll(7, 1'b1);
			rdc("restart code", 8'h08, `TWS_ST_RSTART);
		end
		wr(8'h00, 8'h95);
		poll(4, 1'b0);
		rdc("no flag", 8'h00, 8'h05);
		rdc("idle code", 8'h08, `TWS_ST_NONE);
		wr(8'h04, 8'h5a);
		rdc("data locked", 8'h04, dat);
		$display("transfer test done");
	endtask
	// disable while waiting ends the frame; start without enable is ignored
	task automatic t_abort();
		wr(8'h00, 8'ha5);
		poll(7, 1'b1);
		wr(8'h00, 8'h81);
		repeat (4) @(posedge mclk);
		check("released scl", 8'h01, {7'h0, sclLine});
		rdc("disabled", 8'h00, 8'h01);
		wr(8'h00, 8'ha1);
		repeat (40) @(posedge mclk);
		rdc("no launch", 8'h00, 8'h21);
		rdc("no launch code", 8'h08, `TWS_ST_NONE);
		$display("abort test done");
	endtask
	initial
	begin
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_reset();
		wr(8'h0c, 8'h07);
		t_xfer(8'h54, 8'ha7, 1'b1);
		t_xfer(8'h56, 8'hc3, 1'b0);
		t_abort();
		test_done();
	end
endmodule
`default_nettype wire
